// File: clkcfg_pkg.sv
/*
  Shared constants and types for the clock output configuration block.
  Assumes an APB master with 32-bit data and a single 40 MHz clock.
*/
package clkcfg_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CH0 = 8'h00;
  localparam logic [7:0] OFS_SWING = 8'h24;
  localparam logic [7:0] OFS_LDPRE = 8'h2C;
  localparam logic [7:0] OFS_FILT = 8'h34;
  localparam logic [7:0] OFS_GLOBAL = 8'h38;
  localparam logic [7:0] OFS_STATUS = 8'h40;
  localparam logic [7:0] OFS_DELAY_TAP = 8'h44;
  localparam int NUM_CH = 8;
  // Channel word fields
  localparam int BIT_SRST = 31;
  localparam int PATH_HI = 18;
  localparam int PATH_LO = 17;
  localparam int BIT_CH_EN = 16;
  localparam int DIV_HI = 15;
  localparam int DIV_LO = 8;
  localparam int DLY_HI = 7;
  localparam int DLY_LO = 4;
  // Other fields
  localparam int BIT_BOOST = 16;
  localparam int BIT_LDPRE = 15;
  localparam int FREQ_HI = 21;
  localparam int FREQ_LO = 14;
  localparam int RESB_HI = 13;
  localparam int RESB_LO = 11;
  localparam int RESA_HI = 10;
  localparam int RESA_LO = 8;
  localparam int CAP_HI = 7;
  localparam int CAP_LO = 4;
  localparam int BIT_GLOBAL = 0;
  // Reset values and limits
  localparam logic [7:0] DIV_RST = 8'h01;
  localparam logic [7:0] FREQ_RST = 8'h0A;
  localparam logic [7:0] FREQ_MAX = 8'hC8;
  localparam logic [3:0] CAP_MAX = 4'hB;
  localparam logic [2:0] RES_MAX = 3'h4;
  localparam logic [1:0] LDPRE_DIV = 2'h3;
  // Path select codes
  localparam logic [1:0] PATH_BYPASS = 2'h0;
  localparam logic [1:0] PATH_DIV = 2'h1;
  localparam logic [1:0] PATH_DLY = 2'h2;
  localparam logic [1:0] PATH_DIVDLY = 2'h3;
  // Analog path timing, picoseconds
  localparam int DLY_STEP_PS = 150;
  localparam int DIV_FIXED_PS = 100;
  localparam int DLY_FIXED_PS = 400;
  localparam int BOTH_FIXED_PS = 500;

  typedef struct packed {
    logic [1:0] path;
    logic en;
    logic [7:0] div;
    logic [3:0] dly;
  } chan_cfg_t;

  typedef struct packed {
    chan_cfg_t [NUM_CH-1:0] ch;
    logic boost;
    logic ldpre;
    logic [7:0] freq;
    logic [2:0] resb;
    logic [2:0] resa;
    logic [3:0] cap;
    logic glob;
  } cfg_t;

  typedef struct packed {
    logic [7:0] half;
    logic [7:0] cnt;
    logic lvl;
  } div_st_t;
endpackage : clkcfg_pkg

// File: clock_output_divider_delay_config.sv
/*
  Configuration registers and channel logic for eight clock outputs.
  Assumes a synchronous APB master on mclk; the VCO divider output
  arrives as a one-cycle enable pulse vco_tick synchronous to mclk.
*/
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module clock_output_divider_delay_config #(
  parameter int NCH = clkcfg_pkg::NUM_CH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock inputs and pins
  input wire logic vco_tick,
  input wire logic pdf_tick,
  input wire logic align_pin_n,
  input wire logic outputs_gate_pin,
  // Channel outputs
  output logic [NCH-1:0] clk_out,
  output logic [NCH-1:0] clk_out_en,
  output logic [NCH*2-1:0] path_mode,
  output logic [NCH*4-1:0] delay_tap,
  // Analog configuration
  output logic swing_boost,
  output logic ld_tick,
  output logic [3:0] filter_cap_select,
  output logic [2:0] filter_res_a_select,
  output logic [2:0] filter_res_b_select,
  output logic [7:0] ref_input_mhz,
  output logic bad_code_flag
);

  typedef struct packed {
    clkcfg_pkg::cfg_t cfg;
    clkcfg_pkg::div_st_t [NCH-1:0] dv;
    logic [1:0] ldcnt;
    logic ldt;
    logic bad;
    logic [31:0] rdata;
    logic rdy;
    logic err;
    logic [NCH-1:0] co;
    logic [NCH-1:0] coe;
    logic [NCH*2-1:0] pm;
    logic [NCH*4-1:0] dt;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  clkcfg_pkg::cfg_t cfg_def;

  // Power-on defaults
  always_comb begin
    cfg_def = '0;
    for (int i = 0; i < NCH; i++) begin
      cfg_def.ch[i].div = clkcfg_pkg::DIV_RST;
    end
    cfg_def.freq = clkcfg_pkg::FREQ_RST;
    cfg_def.glob = 1'b1;
  end

  // Next state
  always_comb begin
    logic wr;
    logic rd;
    logic [4:0] idx;
    wr = 1'b0;
    rd = 1'b0;
    idx = '0;
    st_nxt = st_r;
    st_nxt.rdy = 1'b0;
    st_nxt.err = 1'b0;
    wr = psel && penable && !st_r.rdy && pwrite;
    rd = psel && penable && !st_r.rdy && !pwrite;
    idx = paddr[6:2];

    // Register writes
    if (wr) begin
      st_nxt.rdy = 1'b1;
      if (paddr[1:0] != 2'h0) begin
        st_nxt.err = 1'b1;
      end else if (!paddr[7] && int'(idx) < NCH) begin
        if (idx == 5'h0 && pwdata[clkcfg_pkg::BIT_SRST]) begin
          st_nxt.cfg = cfg_def;
          for (int i = 0; i < NCH; i++) begin
            st_nxt.dv[i] = '0;
          end
        end else begin
          st_nxt.cfg.ch[idx[2:0]].path = pwdata[clkcfg_pkg::PATH_HI:clkcfg_pkg::PATH_LO];
          st_nxt.cfg.ch[idx[2:0]].en = pwdata[clkcfg_pkg::BIT_CH_EN];
          st_nxt.cfg.ch[idx[2:0]].div = pwdata[clkcfg_pkg::DIV_HI:clkcfg_pkg::DIV_LO];
          st_nxt.cfg.ch[idx[2:0]].dly = pwdata[clkcfg_pkg::DLY_HI:clkcfg_pkg::DLY_LO];
          if (pwdata[clkcfg_pkg::DIV_HI:clkcfg_pkg::DIV_LO] == 8'h00) begin
            st_nxt.bad = 1'b1;
          end
        end
      end else if (paddr == clkcfg_pkg::OFS_SWING) begin
        st_nxt.cfg.boost = pwdata[clkcfg_pkg::BIT_BOOST];
      end else if (paddr == clkcfg_pkg::OFS_LDPRE) begin
        st_nxt.cfg.ldpre = pwdata[clkcfg_pkg::BIT_LDPRE];
      end else if (paddr == clkcfg_pkg::OFS_FILT) begin
        st_nxt.cfg.freq = pwdata[clkcfg_pkg::FREQ_HI:clkcfg_pkg::FREQ_LO];
        st_nxt.cfg.resb = pwdata[clkcfg_pkg::RESB_HI:clkcfg_pkg::RESB_LO];
        st_nxt.cfg.resa = pwdata[clkcfg_pkg::RESA_HI:clkcfg_pkg::RESA_LO];
        st_nxt.cfg.cap = pwdata[clkcfg_pkg::CAP_HI:clkcfg_pkg::CAP_LO];
        if (pwdata[clkcfg_pkg::CAP_HI:clkcfg_pkg::CAP_LO] > clkcfg_pkg::CAP_MAX
            || pwdata[clkcfg_pkg::RESA_HI:clkcfg_pkg::RESA_LO] > clkcfg_pkg::RES_MAX
            || pwdata[clkcfg_pkg::RESB_HI:clkcfg_pkg::RESB_LO] > clkcfg_pkg::RES_MAX
            || pwdata[clkcfg_pkg::FREQ_HI:clkcfg_pkg::FREQ_LO] == 8'h00
            || pwdata[clkcfg_pkg::FREQ_HI:clkcfg_pkg::FREQ_LO] > clkcfg_pkg::FREQ_MAX) begin
          st_nxt.bad = 1'b1;
        end
      end else if (paddr == clkcfg_pkg::OFS_GLOBAL) begin
        st_nxt.cfg.glob = pwdata[clkcfg_pkg::BIT_GLOBAL];
      end else if (paddr == clkcfg_pkg::OFS_STATUS) begin
        // Write one to bit 0 clears the bad code flag
        if (pwdata[0]) begin
          st_nxt.bad = 1'b0;
        end
      end else begin
        st_nxt.err = 1'b1;
      end
    end

    // Register reads
    if (rd) begin
      st_nxt.rdy = 1'b1;
      st_nxt.rdata = '0;
      if (paddr == clkcfg_pkg::OFS_STATUS) begin
        st_nxt.rdata[0] = st_r.bad;
        st_nxt.rdata[1] = st_r.cfg.glob;
        st_nxt.rdata[2] = outputs_gate_pin;
      end else if (paddr == clkcfg_pkg::OFS_DELAY_TAP) begin
        st_nxt.rdata = st_r.dt;
      end else if (paddr == clkcfg_pkg::OFS_GLOBAL) begin
        st_nxt.rdata[clkcfg_pkg::BIT_GLOBAL] = st_r.cfg.glob;
      end else begin
        st_nxt.err = 1'b1;
      end
    end

    for (int i = 0; i < NCH; i++) begin
      st_nxt.dv[i].half = st_r.cfg.ch[i].div;
      if (!align_pin_n) begin
        st_nxt.dv[i].cnt = '0;
        st_nxt.dv[i].lvl = 1'b0;
      end else if (vco_tick) begin
        // toggle every code ticks gives ratio twice code
        if (st_r.dv[i].cnt + 8'h01 >= st_r.dv[i].half) begin
          st_nxt.dv[i].cnt = '0;
          st_nxt.dv[i].lvl = !st_r.dv[i].lvl;
        end else begin
          st_nxt.dv[i].cnt = st_r.dv[i].cnt + 8'h01;
        end
      end
      case (st_r.cfg.ch[i].path)
        clkcfg_pkg::PATH_DIV, clkcfg_pkg::PATH_DIVDLY: st_nxt.co[i] = st_r.dv[i].lvl;
        default: st_nxt.co[i] = vco_tick;
      endcase
      // delay tap only in delayed modes
      st_nxt.dt[i*4 +: 4] = st_r.cfg.ch[i].path[1] ? st_r.cfg.ch[i].dly : 4'h0;
      // path mode drives analog fixed delays
      st_nxt.pm[i*2 +: 2] = st_r.cfg.ch[i].path;
      st_nxt.coe[i] = st_r.cfg.ch[i].en && st_r.cfg.glob && outputs_gate_pin;
    end

    st_nxt.ldt = 1'b0;
    if (pdf_tick) begin
      if (!st_r.cfg.ldpre) begin
        st_nxt.ldt = 1'b1;
      end else if (st_r.ldcnt == clkcfg_pkg::LDPRE_DIV) begin
        st_nxt.ldcnt = '0;
        st_nxt.ldt = 1'b1;
      end else begin
        st_nxt.ldcnt = st_r.ldcnt + 2'h1;
      end
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
      st_r.cfg <= '0;
      st_r.cfg.freq <= clkcfg_pkg::FREQ_RST;
      st_r.cfg.glob <= 1'b1;
      for (int i = 0; i < NCH; i++) begin
        st_r.cfg.ch[i].div <= clkcfg_pkg::DIV_RST;
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign prdata = st_r.rdata;
  assign pready = st_r.rdy;
  assign pslverr = st_r.err;
  assign clk_out = st_r.co;
  assign clk_out_en = st_r.coe;
  assign path_mode = st_r.pm;
  assign delay_tap = st_r.dt;
  assign swing_boost = st_r.cfg.boost;
  assign ld_tick = st_r.ldt;
  assign filter_cap_select = st_r.cfg.cap;
  assign filter_res_a_select = st_r.cfg.resa;
  assign filter_res_b_select = st_r.cfg.resb;
  assign ref_input_mhz = st_r.cfg.freq;
  assign bad_code_flag = st_r.bad;

endmodule : clock_output_divider_delay_config

// File: clkcfg_assertions.sv
/* Port-level checker for the clock output config block.
   Assumes one clock mclk and synchronous active-high rst. */
`timescale 1ns/1ps
module clkcfg_assertions #(
  parameter int NCH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and outputs
  input wire logic vco_tick,
  input wire logic pdf_tick,
  input wire logic align_pin_n,
  input wire logic outputs_gate_pin,
  input wire logic [NCH-1:0] clk_out,
  input wire logic [NCH-1:0] clk_out_en,
  input wire logic [NCH*2-1:0] path_mode,
  input wire logic [NCH*4-1:0] delay_tap,
  input wire logic ld_tick
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Bus answer timing
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  ready_time_a: assert property (psel && penable && !pready |=> pready) else $error("late pready");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
  // Output gating and path masking
  gate_off_a: assert property (!outputs_gate_pin |=> clk_out_en == '0)
    else $error("output on while gated");
  tap_mask_a: assert property (!path_mode[1] |-> delay_tap[3:0] == 4'h0)
    else $error("delay tap leaks");
  bypass_follow_a: assert property (vco_tick ##1 path_mode[1:0] == 2'h0 |-> clk_out[0])
    else $error("bypass lost tick");
  align_hold_a: assert property ((!align_pin_n && path_mode[0])[*3] |=> !clk_out[0])
    else $error("divider runs during align");
  ld_quiet_a: assert property (!pdf_tick |=> !ld_tick)
    else $error("lock tick without source");
endmodule : clkcfg_assertions
bind clock_output_divider_delay_config clkcfg_assertions #(.NCH(NCH)) chk_i (.*);

// File: tick_source.sv
/* Model of the VCO divider and phase comparator pulse sources.
   Assumes mclk; PERIOD sets the pulse spacing in cycles. */
`timescale 1ns/1ps
module tick_source #(
  parameter int PERIOD = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Pulses
  output logic vco_tick,
  output logic pdf_tick
);
  int cnt_r;
  always_ff @(posedge mclk) begin
    cnt_r <= (rst || cnt_r >= PERIOD - 1) ? 0 : cnt_r + 1;
    vco_tick <= !rst && cnt_r == 0;
    pdf_tick <= !rst && cnt_r == 0;
  end
endmodule : tick_source

// File: clock_output_divider_delay_config_bench.sv
/* Self-checking bench for the clock output config block.
   Assumes APB master tasks here and tick_source for the pulses. */
`timescale 1ns/1ps
module clock_output_divider_delay_config_bench;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, vco_tick, pdf_tick, err;
  logic align_pin_n, outputs_gate_pin, swing_boost, ld_tick, bad_code_flag;
  logic [7:0] paddr, ref_input_mhz, clk_out, clk_out_en;
  logic [31:0] pwdata, prdata, rd, delay_tap;
  logic [15:0] path_mode;
  logic [3:0] filter_cap_select;
  logic [2:0] filter_res_a_select, filter_res_b_select;
  logic [31:0] bad_w [4] = '{32'h001919C0, 32'h00324000, 32'h00000500, 32'h00002800};
  int n_mismatch = 0, n_tests = 0, cyc = 0, rise, high;
  clock_output_divider_delay_config dut (.mclk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .vco_tick, .pdf_tick, .align_pin_n,
    .outputs_gate_pin, .clk_out, .clk_out_en, .path_mode, .delay_tap, .swing_boost,
    .ld_tick, .filter_cap_select, .filter_res_a_select, .filter_res_b_select,
    .ref_input_mhz, .bad_code_flag);
  tick_source #(.PERIOD(1)) src (.mclk, .rst, .vco_tick, .pdf_tick);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, then two edges so config reaches the outputs
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask : apb
  // Counts rising edges and high cycles over a window
  task meas(input logic ld, input int ch, input int win);
    logic prev, cur;
    rise = 0;
    high = 0;
    prev = ld ? ld_tick : clk_out[ch];
    repeat (win) begin
      @(posedge mclk);
      #1;
      cur = ld ? ld_tick : clk_out[ch];
      rise += int'(cur && !prev);
      high += int'(cur);
      prev = cur;
    end
  endtask : meas
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // Clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Timeout
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // Main sequence
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {3'h4, 41'h0};
    {align_pin_n, outputs_gate_pin} = 2'h3;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    apb(0, 8'h40, 0);
    chk(rd[2:0], 3'h6);
    chk({swing_boost, filter_cap_select, ref_input_mhz}, 13'h00A);
    $display("test defaults done");
    apb(1, 8'h34, 32'h001919B0);
    chk({ref_input_mhz, filter_res_b_select, filter_res_a_select}, 14'h1919);
    chk({filter_cap_select, bad_code_flag}, 5'h16);
    foreach (bad_w[i]) begin
      apb(1, 8'h34, bad_w[i]);
      chk(bad_code_flag, 1'b1);
      apb(1, 8'h40, 1);
      chk(bad_code_flag, 1'b0);
    end
    $display("test filter done");
    apb(1, 8'h08, 32'h00070250);
    apb(1, 8'h0C, 32'h00010090);
    apb(1, 8'h04, 32'h000501F0);
    chk({path_mode[7:2], delay_tap[15:4]}, 18'h0E05F);
    chk(clk_out_en, 8'h0E);
    meas(0, 2, 40);
    chk(rise, 10);
    chk(high, 20);
    meas(0, 1, 40);
    chk(high, 40);
    apb(1, 8'h08, 32'h0003FF00);
    meas(0, 2, 1020);
    chk(rise, 2);
    chk(high, 510);
    $display("test channels done");
    @(posedge mclk);
    outputs_gate_pin <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(clk_out_en, 8'h00);
    outputs_gate_pin <= 1'b1;
    apb(1, 8'h38, 0);
    chk(clk_out_en, 8'h00);
    apb(1, 8'h38, 1);
    chk(clk_out_en, 8'h0E);
    apb(1, 8'h00, 32'h00030100);
    align_pin_n <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk(clk_out[0], 1'b0);
    align_pin_n <= 1'b1;
    $display("test enables done");
    apb(1, 8'h24, 32'h00010000);
    chk(swing_boost, 1'b1);
    meas(1, 0, 40);
    chk(high, 40);
    apb(1, 8'h2C, 32'h00008000);
    meas(1, 0, 40);
    chk(rise, 10);
    chk(high, 10);
    apb(1, 8'h80, 1);
    chk(err, 1'b1);
    apb(0, 8'h08, 0);
    chk(err, 1'b1);
    apb(1, 8'h00, 32'h80070250);
    chk(path_mode, 0);
    chk(delay_tap, 0);
    chk(clk_out_en, 0);
    chk({swing_boost, ref_input_mhz}, 9'h00A);
    meas(1, 0, 40);
    chk(high, 40);
    $display("test soft reset done");
    print_verdict();
  end
endmodule : clock_output_divider_delay_config_bench
